// file: dv/pin_board_model.sv
`timescale 1ns/10ps
module pin_board_model (
  // Device side of each line
  input wire logic [1:0] pin_out_in,
  input wire logic [1:0] pin_oe_n_in,
  // Board pull-down switches
  input wire logic [1:0] ext_low_in,
  output logic [1:0] level_out
);
  // Lines idle high through board pull-ups; a board switch can only sink
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (!pin_oe_n_in[i]) begin
        level_out[i] = pin_out_in[i];
      end else begin
        level_out[i] = !ext_low_in[i];
      end
    end
  end
endmodule

// file: dv/pmic_gpio_pin_control_tb_top.sv
`timescale 1ns/10ps
module pmic_gpio_pin_control_tb_top;
  import pmic_gpio_pkg::*;
  localparam int FILT = 8;
  localparam logic [7:0] WV [4] = '{8'h0C, 8'h04, 8'h08, 8'h00};
  localparam logic [1:0] PV [4] = '{2'b10, 2'b00, 2'b01, 2'b00};
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, slverr, seq2, use_alt;
  logic [11:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, rdata;
  logic [1:0] lvl, pout, oe_n, ext_low;
  logic [7:0] tv_a, tv_b, tv_out;
  int n_fail, samples_checked;

  pmic_gpio_pin_control #(.FILTER_CYCLES(FILT)) u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PSTRB_IN(pstrb), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PIN_IN(lvl),
    .PIN_OUT(pout), .PIN_OE_N_OUT(oe_n), .RAIL0_TARGET_VOLTAGE_IN(tv_a),
    .RAIL0_ALTERNATE_TARGET_VOLTAGE_IN(tv_b), .RAIL2_SEQ_OUT_IN(seq2), .RAIL0_TARGET_OUT(tv_out),
    .RAIL0_USE_ALTERNATE_OUT(use_alt));
  pin_board_model u_board (.pin_out_in(pout), .pin_oe_n_in(oe_n), .ext_low_in(ext_low), .level_out(lvl));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    // Read data and error are taken at the edge that sees ready high
    rdata = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: no ready", $time);
      end_sim();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rdata, exp);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask

  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, seq2} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    tv_a = 8'h11;
    tv_b = 8'h22;
    ext_low = 2'b00;
    n_fail = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // Let the pin levels pass the synchroniser before the first readback
    tick(3);
    rd(12'h020, 32'h3);
    rd(12'h024, 32'h3);
    cmp({24'h0, tv_out}, 32'h11);
    apb(1'b1, 12'h020, 32'h0D);
    @(posedge clk);
    ext_low <= 2'b01;
    tick(4);
    cmp({30'h0, oe_n}, 32'h3);
    rd(12'h020, 32'h0D);
    @(posedge clk);
    ext_low <= 2'b00;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h020, {24'h0, WV[i]});
      tick(4);
      cmp({30'h0, pout[0], oe_n[0]}, {30'h0, PV[i]});
      rd(12'h020, {24'h0, WV[i] | {6'h0, |PV[i], 1'b0}});
    end
    apb(1'b1, 12'h020, 32'h20);
    tick(2);
    cmp({23'h0, use_alt, tv_out}, {23'h0, 1'b1, 8'h22});
    apb(1'b1, 12'h024, 32'h21);
    for (int i = 1; i >= 0; i--) begin
      @(posedge clk);
      seq2 <= 1'(i);
      tick(3);
      cmp({30'h0, pout[1], oe_n[1]}, {30'h0, 1'(i), 1'b0});
    end
    apb(1'b1, 12'h024, 32'h11);
    tick(FILT + 4);
    rd(12'h024, 32'h13);
    // A bounce shorter than the filter interval must not reach the readback
    @(posedge clk);
    ext_low <= 2'b10;
    repeat (FILT - 4) @(posedge clk);
    ext_low <= 2'b00;
    tick(4);
    rd(12'h024, 32'h13);
    // First read captures on the same edge that accepts the new level, so it still sees the old one
    @(posedge clk);
    ext_low <= 2'b10;
    tick(FILT);
    rd(12'h024, 32'h13);
    rd(12'h024, 32'h11);
    // A write with byte lane 0 disabled must leave the register alone
    @(posedge clk);
    pstrb <= 4'h0;
    apb(1'b1, 12'h024, 32'h00);
    pstrb <= 4'hF;
    rd(12'h024, 32'h11);
    rd(12'h028, 32'h0);
    cmp({31'h0, slverr}, 32'h1);
    end_sim();
  end
endmodule

// file: inc/pmic_gpio_map.svh
`ifndef PMIC_GPIO_MAP_SVH
`define PMIC_GPIO_MAP_SVH
// Register indices; byte address is four times the index
`define PIN0_CONFIG_IDX 10'h008
`define PIN1_CONFIG_IDX 10'h009
// Field positions inside each pin register
`define FLD_DIRECTION 0
`define FLD_LEVEL 1
`define FLD_DRIVER_TYPE 2
`define FLD_OUT_LEVEL 3
`define FLD_FILTER_ON 4
`define FLD_ALT_FUNC 5
// Reset values
`define RST_DIRECTION 1'h1
`define RST_DRIVER_TYPE 1'h0
`define RST_OUT_LEVEL 1'h0
`define RST_FILTER_ON 1'h0
`define RST_ALT_FUNC 1'h0
// Timing
`define FILTER_TIME_MS 30
`define CLK_RATE_HZ 125000000
`define MS_PER_S 1000
`define FILTER_CYCLES (`FILTER_TIME_MS * (`CLK_RATE_HZ / `MS_PER_S))
`define PIN_COUNT 2
`endif

// file: inc/pmic_gpio_pkg.sv
`include "pmic_gpio_map.svh"
package pmic_gpio_pkg;
  typedef logic [7:0] pin_reg_t;
  typedef logic [`PIN_COUNT-1:0] pin_vec_t;
  typedef enum logic {DIR_OUTPUT, DIR_INPUT} pin_dir_t;
  typedef enum logic {DRIVE_OPEN_DRAIN, DRIVE_PUSH_PULL} drive_t;
endpackage

// file: src/pmic_gpio_pin_control.sv
`timescale 1ns/10ps
`include "pmic_gpio_map.svh"
module pmic_gpio_pin_control
  import pmic_gpio_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int FILTER_CYCLES = `FILTER_CYCLES,
  parameter logic PIN0_ALT_RESET = `RST_ALT_FUNC,
  parameter logic PIN1_ALT_RESET = `RST_ALT_FUNC
) (
  // Clock, reset, enable
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Pins, tri-state style three-signal form
  input wire logic [`PIN_COUNT-1:0] PIN_IN,
  output logic [`PIN_COUNT-1:0] PIN_OUT,
  output logic [`PIN_COUNT-1:0] PIN_OE_N_OUT,
  // Regulator side
  input wire logic [7:0] RAIL0_TARGET_VOLTAGE_IN,
  input wire logic [7:0] RAIL0_ALTERNATE_TARGET_VOLTAGE_IN,
  input wire logic RAIL2_SEQ_OUT_IN,
  output logic [7:0] RAIL0_TARGET_OUT,
  output logic RAIL0_USE_ALTERNATE_OUT
);
  localparam int CNT_W = $clog2(FILTER_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FILTER_CYCLES - 1);

  // Refused at elaboration: the filter counter needs two states and the decode twelve address bits
  if (FILTER_CYCLES < 2 || ADDR_W < 12) begin : g_param_check
    $error("pmic_gpio_pin_control: unsupported parameter values");
  end

  // Configuration bits, one per pin; then the captured read data and error flag
  pin_vec_t dir_ff, nxt_dir;
  pin_vec_t dtype_ff, nxt_dtype;
  pin_vec_t dout_ff, nxt_dout;
  pin_vec_t dben_ff, nxt_dben;
  pin_vec_t alt_ff, nxt_alt;
  logic [31:0] rdata_ff, nxt_rdata;
  logic slverr_ff, nxt_slverr;

  // Input path
  pin_vec_t sync1_ff, sync2_ff;
  pin_vec_t level_ff, nxt_level;
  logic [CNT_W-1:0] cnt_ff [`PIN_COUNT];
  logic [CNT_W-1:0] nxt_cnt [`PIN_COUNT];

  // Output path
  pin_vec_t pout_ff, nxt_pout;
  pin_vec_t poe_n_ff, nxt_poe_n;
  logic [7:0] target_ff, nxt_target;

  logic setup_phase, access_wr, sel0, sel1;
  logic [ADDR_W-3:0] word_idx;

  assign word_idx = PADDR_IN[ADDR_W-1:2];
  assign sel0 = (word_idx == (ADDR_W-2)'(`PIN0_CONFIG_IDX));
  assign sel1 = (word_idx == (ADDR_W-2)'(`PIN1_CONFIG_IDX));
  assign setup_phase = PSEL_IN && !PENABLE_IN;
  assign access_wr = PSEL_IN && PENABLE_IN && PWRITE_IN && PSTRB_IN[0] && !slverr_ff;

  // Zero-wait slave: read data is captured in the setup cycle
  assign PREADY_OUT = 1'b1;
  assign PRDATA_OUT = rdata_ff;
  assign PSLVERR_OUT = slverr_ff && PSEL_IN && PENABLE_IN;

  function automatic pin_reg_t pack_reg(input int i);
    pin_reg_t r;
    r = '0;
    r[`FLD_DIRECTION] = dir_ff[i];
    r[`FLD_LEVEL] = level_ff[i];
    r[`FLD_DRIVER_TYPE] = dtype_ff[i];
    r[`FLD_OUT_LEVEL] = dout_ff[i];
    r[`FLD_FILTER_ON] = dben_ff[i];
    r[`FLD_ALT_FUNC] = alt_ff[i];
    return r;
  endfunction

  // Register file
  always_comb begin
    nxt_dir = dir_ff;
    nxt_dtype = dtype_ff;
    nxt_dout = dout_ff;
    nxt_dben = dben_ff;
    nxt_alt = alt_ff;
    nxt_rdata = rdata_ff;
    nxt_slverr = slverr_ff;
    if (setup_phase) begin
      nxt_slverr = !(sel0 || sel1);
      nxt_rdata = '0;
      if (sel0) begin
        nxt_rdata = {24'h000000, pack_reg(0)};
      end else if (sel1) begin
        nxt_rdata = {24'h000000, pack_reg(1)};
      end
    end
    // Unused bits are not stored and read back as zero
    for (int i = 0; i < `PIN_COUNT; i++) begin
      if (access_wr && ((i == 0) ? sel0 : sel1)) begin
        nxt_dir[i] = PWDATA_IN[`FLD_DIRECTION];
        nxt_dtype[i] = PWDATA_IN[`FLD_DRIVER_TYPE];
        nxt_dout[i] = PWDATA_IN[`FLD_OUT_LEVEL];
        nxt_dben[i] = PWDATA_IN[`FLD_FILTER_ON];
        nxt_alt[i] = PWDATA_IN[`FLD_ALT_FUNC];
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      dir_ff <= {`PIN_COUNT{`RST_DIRECTION}};
      dtype_ff <= {`PIN_COUNT{`RST_DRIVER_TYPE}};
      dout_ff <= {`PIN_COUNT{`RST_OUT_LEVEL}};
      dben_ff <= {`PIN_COUNT{`RST_FILTER_ON}};
      alt_ff <= {PIN1_ALT_RESET, PIN0_ALT_RESET};
      rdata_ff <= '0;
      slverr_ff <= 1'b0;
    end else if (CE_IN) begin
      dir_ff <= nxt_dir;
      dtype_ff <= nxt_dtype;
      dout_ff <= nxt_dout;
      dben_ff <= nxt_dben;
      alt_ff <= nxt_alt;
      rdata_ff <= nxt_rdata;
      slverr_ff <= nxt_slverr;
    end
  end

  // Pin synchroniser
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else if (CE_IN) begin
      sync1_ff <= PIN_IN;
      sync2_ff <= sync1_ff;
    end
  end

  // Debounce: a change must hold for the whole interval before it is accepted
  always_comb begin
    nxt_level = level_ff;
    for (int i = 0; i < `PIN_COUNT; i++) begin
      nxt_cnt[i] = '0;
      if (!dben_ff[i]) begin
        nxt_level[i] = sync2_ff[i];
      end else if (sync2_ff[i] != level_ff[i]) begin
        if (cnt_ff[i] == CNT_LAST) begin
          nxt_level[i] = sync2_ff[i];
        end else begin
          nxt_cnt[i] = cnt_ff[i] + CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      level_ff <= '0;
      for (int i = 0; i < `PIN_COUNT; i++) begin
        cnt_ff[i] <= '0;
      end
    end else if (CE_IN) begin
      level_ff <= nxt_level;
      for (int i = 0; i < `PIN_COUNT; i++) begin
        cnt_ff[i] <= nxt_cnt[i];
      end
    end
  end

  // Pin drivers and rail 0 target selection
  always_comb begin
    nxt_pout = '0;
    nxt_poe_n = '1;
    for (int i = 0; i < `PIN_COUNT; i++) begin
      if (i == 1 && alt_ff[i]) begin
        nxt_pout[i] = RAIL2_SEQ_OUT_IN;
        nxt_poe_n[i] = 1'b0;
      end else if (pin_dir_t'(dir_ff[i]) == DIR_OUTPUT) begin
        if (drive_t'(dtype_ff[i]) == DRIVE_PUSH_PULL) begin
          nxt_pout[i] = dout_ff[i];
          nxt_poe_n[i] = 1'b0;
        end else begin
          // Open drain only ever pulls low; high is released
          nxt_pout[i] = 1'b0;
          nxt_poe_n[i] = dout_ff[i];
        end
      end
    end
    nxt_target = alt_ff[0] ? RAIL0_ALTERNATE_TARGET_VOLTAGE_IN : RAIL0_TARGET_VOLTAGE_IN;
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pout_ff <= '0;
      poe_n_ff <= '1;
      target_ff <= '0;
    end else if (CE_IN) begin
      pout_ff <= nxt_pout;
      poe_n_ff <= nxt_poe_n;
      target_ff <= nxt_target;
    end
  end

  assign PIN_OUT = pout_ff;
  assign PIN_OE_N_OUT = poe_n_ff;
  assign RAIL0_TARGET_OUT = target_ff;
  assign RAIL0_USE_ALTERNATE_OUT = alt_ff[0];

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_input_releases: assert property ($past(CE_IN) && $past(dir_ff[0]) |-> PIN_OE_N_OUT[0])
    else $error("input pin 0 is driven");
  a_out_push_pull: assert property (
    $past(CE_IN) && !$past(dir_ff[0]) && $past(dtype_ff[0])
    |-> !PIN_OE_N_OUT[0] && PIN_OUT[0] == $past(dout_ff[0]))
    else $error("push-pull pin 0 wrong drive");
  a_open_drain_level: assert property (
    $past(CE_IN) && !$past(dir_ff[0]) && !$past(dtype_ff[0])
    |-> PIN_OE_N_OUT[0] == $past(dout_ff[0]) && !PIN_OUT[0])
    else $error("open-drain pin 0 wrong drive");
  a_input_ignores_cfg: assert property (
    $past(CE_IN) && $past(dir_ff[0]) && $stable(dir_ff[0]) && CE_IN ##1 1'b1
    |-> PIN_OE_N_OUT[0] && !PIN_OUT[0])
    else $error("input pin 0 reacted to output bits");
  a_readback_level: assert property (
    CE_IN && setup_phase && sel1 |=> PRDATA_OUT[`FLD_LEVEL] == $past(level_ff[1]))
    else $error("readback does not show pin 1 level");
  a_filter_off_follow: assert property (CE_IN && !dben_ff[0] |=> level_ff[0] == $past(sync2_ff[0]))
    else $error("unfiltered level not following pin 0");
  // Registered outputs still show reset values one edge after release
  a_rail0_select: assert property (
    $past(CE_IN) && $past(RST_N_IN) |-> RAIL0_TARGET_OUT == ($past(alt_ff[0])
    ? $past(RAIL0_ALTERNATE_TARGET_VOLTAGE_IN) : $past(RAIL0_TARGET_VOLTAGE_IN)))
    else $error("rail 0 target source wrong");
  a_rail2_seq_pin: assert property (
    $past(CE_IN) && $past(RST_N_IN) && $past(alt_ff[1])
    |-> !PIN_OE_N_OUT[1] && PIN_OUT[1] == $past(RAIL2_SEQ_OUT_IN))
    else $error("pin 1 not carrying sequencer output");
  a_filter_hold: assert property (
    CE_IN && dben_ff[1] && cnt_ff[1] != CNT_LAST |=> $stable(level_ff[1]))
    else $error("filtered level changed early");
endmodule
